// [common/dma_channel_control_regs_consts.svh]
// Constants for the two-sub-channel transfer controller
`ifndef DMA_CHANNEL_CONTROL_REGS_CONSTS_SVH
`define DMA_CHANNEL_CONTROL_REGS_CONSTS_SVH

`define KIND_CTRL     2'h0
`define KIND_MAR      2'h1
`define KIND_IO_ADDRESS     2'h2
`define KIND_CNT      2'h3
`define SUB_BIT       4
`define EN_BIT        7
`define SIZE_BIT      6
`define DIR_BIT       5
`define RPE_BIT       4
`define IE_BIT        3
`define BLK_BIT       0
`define CTRL_RST      8'h00
`define TOP_BYTE      8'hFF
`define IO_UPPER      24'hFFFFFF
`define SEL_RX        3'h5
`define SEL_EXT_EDGE  3'h6
`define SEL_EXT_LVL   3'h7
`define NUM_TRIG      6
`define STEP_BYTE     24'h000001
`define STEP_WORD     24'h000002

`endif

// [common/dma_channel_control_regs_pkg.sv]
// Types shared by the transfer controller and its users
package dma_channel_control_regs_pkg;

   // Transfer request handed to the bus side
   typedef struct packed {
      logic [31:0] src;
      logic [31:0] dst;
      logic        word;
      logic        sub;
   } xfer_t;

   // Transfer sequencer, Gray along idle, request, update
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_REQ  = 2'b01,
      ST_UPD  = 2'b11
   } state_t;

endpackage

// [logic/dma_channel_control_regs.sv]
// Two-sub-channel transfer controller with APB registers
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "dma_channel_control_regs_consts.svh"

module dma_channel_control_regs #(
   parameter int ADDR_W = 8,
   parameter int MAR_W  = 24
) (
   input  wire logic                                 CLK_SYS,   // System clock, 50 MHz
   input  wire logic                                 RSTN,      // Asynchronous reset, active low
   input  wire logic                                 STANDBY,   // Standby mode level
   input  wire logic                                 PSEL,      // APB select
   input  wire logic                                 PENABLE,   // APB access phase
   input  wire logic                                 PWRITE,    // APB direction
   input  wire logic [ADDR_W-1:0]                    PADDR,     // APB byte address
   input  wire logic [31:0]                          PWDATA,    // APB write data
   output logic      [31:0]                          PRDATA,    // APB read data
   output logic                                      PREADY,    // APB ready
   output logic                                      PSLVERR,   // APB error on unmapped address
   input  wire logic [`NUM_TRIG-1:0]                 TRIG_IN,   // Peripheral interrupt sources
   output logic      [`NUM_TRIG-1:0]                 IRQ_OUT,   // Sources passed to the CPU
   input  wire logic                                 EXT_REQ_N, // External request pin, active low
   output logic                                      XFER_REQ,  // Transfer request to the bus
   output dma_channel_control_regs_pkg::xfer_t       XFER,      // Transfer addresses and size
   input  wire logic                                 XFER_ACK,  // Bus has done the transfer
   output logic      [1:0]                           END_IRQ    // Transfer end interrupt pulses
);

   // Register banks; index 0 is sub-channel A, index 1 is B
   logic [7:0]       ctrl      [2];
   logic [MAR_W-1:0] memory_address       [2];
   logic [7:0]       io_address      [2];
   logic [15:0]      cnt       [2];

   // Values for the update cycle
   logic [MAR_W-1:0] next_mar  [2];
   logic [15:0]      next_cnt  [2];
   logic [1:0]       finish;
   logic [1:0]       armed;
   logic [1:0]       pend;
   logic [1:0]       live;
   logic [1:0]       hit;
   logic [1:0]       serve;
   logic [1:0]       en_eff;
   logic [2:0]       sel_eff   [2];

   // Edge history of the enables and the request pin
   logic [1:0]       en_q;
   logic             ext_q;
   logic             ext_fall;

   // Mode, winner and its addresses
   logic             full_mode;
   logic             cur;
   logic             word;
   logic [31:0]      pick_src;
   logic [31:0]      pick_dst;
   logic             pick_sub;
   logic [`NUM_TRIG-1:0] blocked;

   // Register bus decode
   logic [3:0]       dec_rd;
   logic [3:0]       dec_wr;
   logic             setup;
   logic             wr_acc;
   dma_channel_control_regs_pkg::state_t st;

   // Address decode: {valid, sub, kind}; the upper address bits must be zero
   // Holes answer with an error so a stray pointer shows up at once
   function automatic logic [3:0] reg_decode(input logic [ADDR_W-1:0] a);
      logic ok;
      ok = (a[1:0] == 2'h0) && ((a >> (`SUB_BIT + 1)) == '0);
      return {ok, a[`SUB_BIT], a[3:2]};
   endfunction

   // Trigger of one sub-channel; external pin only where allowed
   // A has no pin path in short mode, so its codes 6 and 7 stay quiet
   function automatic logic trig_of(input logic [2:0] sel, input logic ext_ok,
                                    input logic [`NUM_TRIG-1:0] src, input logic fall,
                                    input logic pin_n);
      logic t;
      t = 1'b0;
      if (sel < `SEL_EXT_EDGE) begin
         t = src[sel];
      end else if (ext_ok) begin
         t = (sel == `SEL_EXT_EDGE) ? fall : ~pin_n;
      end
      return t;
   endfunction

   // Memory address step by unit size
   // Wraps at the end of the space; software must keep runs inside it
   function automatic logic [MAR_W-1:0] step_addr(input logic [MAR_W-1:0] a, input logic dn,
                                                  input logic wd);
      logic [MAR_W-1:0] s;
      s = wd ? MAR_W'(`STEP_WORD) : MAR_W'(`STEP_BYTE);
      return dn ? a - s : a + s;
   endfunction

   // APB phases; zero wait states, so the access phase always completes
   // No wait state is ever needed, which is why PREADY is tied high
   assign setup     = PSEL & ~PENABLE;
   assign wr_acc    = PSEL & PENABLE & PWRITE & dec_wr[3];
   assign dec_rd    = reg_decode(PADDR);
   assign dec_wr    = dec_rd;
   assign PREADY    = 1'b1;
   assign PSLVERR   = PSEL & PENABLE & ~dec_rd[3];
   assign full_mode = (ctrl[0][2:1] == 2'b11);
   assign ext_fall  = ext_q & ~EXT_REQ_N;

   // A pending bit counts only while its enable stands, so one left over
   // from the last transfer of a run cannot start a stray transfer
   assign live      = pend & en_eff;

   // Effective enable and source; in full mode A enables and B selects the source
   // B's own enable is ignored in full mode so a stale B setting cannot fire
   always_comb begin
      en_eff[0]  = ctrl[0][`EN_BIT];
      en_eff[1]  = ctrl[1][`EN_BIT] & ~full_mode;
      sel_eff[0] = full_mode ? ctrl[1][2:0] : ctrl[0][2:0];
      sel_eff[1] = ctrl[1][2:0];
   end

   // Requests count only while enabled
   // A source that no enabled sub-channel selects is dropped here
   always_comb begin
      hit[0] = en_eff[0] & trig_of(sel_eff[0], full_mode, TRIG_IN, ext_fall, EXT_REQ_N);
      hit[1] = en_eff[1] & trig_of(sel_eff[1], 1'b1, TRIG_IN, ext_fall, EXT_REQ_N);
   end

   // Enabled sub-channels swallow their source's CPU interrupt
   // Masking is combinational so the CPU never sees a request the engine owns
   always_comb begin
      blocked = '0;
      for (int k = 0; k < `NUM_TRIG; k++) begin
         for (int i = 0; i < 2; i++) begin
            if (en_eff[i] && sel_eff[i] == 3'(k)) begin
               blocked[k] = 1'b1;
            end
         end
      end
      IRQ_OUT = TRIG_IN & ~blocked;
   end

   // Address selection for the winner; A wins when both are pending
   always_comb begin
      pick_sub = ~live[0];
      pick_src = '0;
      pick_dst = '0;
      // I/O address registers sit idle in full mode
      if (full_mode) begin
         pick_src = {`TOP_BYTE, memory_address[0]};
         pick_dst = {`TOP_BYTE, memory_address[1]};
      end else if (sel_eff[pick_sub] == `SEL_RX) begin
         pick_src = {`IO_UPPER, io_address[pick_sub]};
         pick_dst = {`TOP_BYTE, memory_address[pick_sub]};
      end else begin
         pick_src = {`TOP_BYTE, memory_address[pick_sub]};
         pick_dst = {`IO_UPPER, io_address[pick_sub]};
      end
   end

   // Size of the running transfer
   // Full mode takes the size from A, the channel's master register
   assign word = full_mode ? ctrl[0][`SIZE_BIT] : ctrl[cur][`SIZE_BIT];

   // Counter and address update after a finished transfer
   always_comb begin
      logic [7:0]  hi;
      logic [15:0] c;
      logic [7:0]  k;
      hi       = 8'h00;
      c        = 16'h0000;
      k        = 8'h00;
      next_mar = memory_address;
      next_cnt = cnt;
      finish   = 2'b00;
      if (st == dma_channel_control_regs_pkg::ST_UPD) begin
         if (full_mode) begin
            // Source and destination each step on their own enable bit
            if (ctrl[0][`RPE_BIT]) begin
               next_mar[0] = step_addr(memory_address[0], ctrl[0][`DIR_BIT], word);
            end
            if (ctrl[1][`RPE_BIT]) begin
               next_mar[1] = step_addr(memory_address[1], ctrl[1][`DIR_BIT], word);
            end
            if (!ctrl[0][`BLK_BIT]) begin
               c           = cnt[0] - 16'h0001;
               next_cnt[0] = c;
               finish[0]   = (c == 16'h0000);
            end else begin
               // The block counter moves only when the unit count empties
               hi = cnt[0][15:8] - 8'h01;
               if (hi == 8'h00) begin
                  next_cnt[0] = {cnt[0][7:0], cnt[0][7:0]};
                  c           = cnt[1] - 16'h0001;
                  next_cnt[1] = c;
                  finish[0]   = (c == 16'h0000);
               end else begin
                  next_cnt[0] = {hi, cnt[0][7:0]};
               end
            end
         end else begin
            k = ctrl[cur];
            if (!(k[`RPE_BIT] && k[`IE_BIT])) begin
               next_mar[cur] = step_addr(memory_address[cur], k[`DIR_BIT], word);
            end
            if (!k[`RPE_BIT] || k[`IE_BIT]) begin
               c             = cnt[cur] - 16'h0001;
               next_cnt[cur] = c;
               finish[cur]   = (c == 16'h0000);
            end else begin
               hi = cnt[cur][15:8] - 8'h01;
               next_cnt[cur] = (hi == 8'h00) ? {cnt[cur][7:0], cnt[cur][7:0]}
                                             : {hi, cnt[cur][7:0]};
            end
         end
      end
   end

   // Address, I/O address and count keep their contents through reset
   // A bus write wins over a same-cycle hardware step
   always_ff @(posedge CLK_SYS) begin
      for (int i = 0; i < 2; i++) begin
         if (wr_acc && dec_wr[2] == 1'(i) && dec_wr[1:0] == `KIND_MAR) begin
            memory_address[i] <= PWDATA[MAR_W-1:0];
         end else begin
            memory_address[i] <= next_mar[i];
         end
         if (wr_acc && dec_wr[2] == 1'(i) && dec_wr[1:0] == `KIND_IO_ADDRESS) begin
            io_address[i] <= PWDATA[7:0];
         end
         if (wr_acc && dec_wr[2] == 1'(i) && dec_wr[1:0] == `KIND_CNT) begin
            cnt[i] <= PWDATA[15:0];
         end else begin
            cnt[i] <= next_cnt[i];
         end
      end
   end

   // Control registers; end of count overrides a simultaneous write of enable
   // Standby is a synchronous clear; the registers read zero while it lasts
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         ctrl[0] <= `CTRL_RST;
         ctrl[1] <= `CTRL_RST;
      end else if (STANDBY) begin
         ctrl[0] <= `CTRL_RST;
         ctrl[1] <= `CTRL_RST;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (wr_acc && dec_wr[2] == 1'(i) && dec_wr[1:0] == `KIND_CTRL) begin
               ctrl[i][6:0]     <= PWDATA[6:0];
               ctrl[i][`EN_BIT] <= PWDATA[`EN_BIT] & (armed[i] | ctrl[i][`EN_BIT]);
            end
            if (finish[i]) begin
               ctrl[i][`EN_BIT] <= 1'b0;
            end
         end
      end
   end

   // Read of a clear enable arms the next write of one
   // Any write to the register uses up the arming, with or without enable
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         armed <= 2'b00;
      end else if (STANDBY) begin
         armed <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (wr_acc && dec_wr[2] == 1'(i) && dec_wr[1:0] == `KIND_CTRL) begin
               armed[i] <= 1'b0;
            end else if (setup && !PWRITE && dec_rd[3] && dec_rd[2] == 1'(i) &&
                         dec_rd[1:0] == `KIND_CTRL && !ctrl[i][`EN_BIT]) begin
               armed[i] <= 1'b1;
            end
         end
      end
   end

   // End interrupt on every fall of enable while the interrupt bit is set
   // A software clear of enable raises the pulse as well as the end of count
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         en_q    <= 2'b00;
         END_IRQ <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            en_q[i]    <= ctrl[i][`EN_BIT];
            END_IRQ[i] <= en_q[i] & ~ctrl[i][`EN_BIT] & ctrl[i][`IE_BIT];
         end
      end
   end

   // Pending requests; a new request in the serving cycle is kept
   // A low pin in level mode refills the pending bit every cycle
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         pend  <= 2'b00;
         ext_q <= 1'b1;
      end else begin
         ext_q <= EXT_REQ_N;
         for (int i = 0; i < 2; i++) begin
            pend[i] <= en_eff[i] & (hit[i] | (pend[i] & ~serve[i]));
         end
      end
   end

   // One transfer at a time
   // Only one sub-channel is served per idle cycle; the other keeps its bit
   always_comb begin
      serve = 2'b00;
      if (st == dma_channel_control_regs_pkg::ST_IDLE && live != 2'b00) begin
         serve[pick_sub] = 1'b1;
      end
   end

   // Transfer sequencer
   // Addresses are frozen at the grant so they stand while the bus waits
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         st   <= dma_channel_control_regs_pkg::ST_IDLE;
         cur  <= 1'b0;
         XFER <= '0;
      end else begin
         case (st)
            dma_channel_control_regs_pkg::ST_IDLE: begin
               if (live != 2'b00) begin
                  cur       <= pick_sub;
                  XFER.src  <= pick_src;
                  XFER.dst  <= pick_dst;
                  XFER.sub  <= pick_sub;
                  XFER.word <= full_mode ? ctrl[0][`SIZE_BIT] : ctrl[pick_sub][`SIZE_BIT];
                  st        <= dma_channel_control_regs_pkg::ST_REQ;
               end
            end
            dma_channel_control_regs_pkg::ST_REQ: begin
               if (XFER_ACK) begin
                  st <= dma_channel_control_regs_pkg::ST_UPD;
               end
            end
            dma_channel_control_regs_pkg::ST_UPD: begin
               st <= dma_channel_control_regs_pkg::ST_IDLE;
            end
            default: begin
               st <= dma_channel_control_regs_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Handshake straight from state; it drops in the cycle after acknowledge
   assign XFER_REQ = (st == dma_channel_control_regs_pkg::ST_REQ);

   // Read data captured in the setup cycle so it is a flop in the access phase
   // Writes never disturb it; it stands until the next read setup
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         PRDATA <= '0;
      end else if (setup && !PWRITE) begin
         PRDATA <= '0;
         if (dec_rd[3]) begin
            case (dec_rd[1:0])
               `KIND_CTRL: PRDATA <= {24'h000000, ctrl[dec_rd[2]]};
               `KIND_MAR:  PRDATA <= {`TOP_BYTE, memory_address[dec_rd[2]]};
               `KIND_IO_ADDRESS: PRDATA <= {24'h000000, io_address[dec_rd[2]]};
               `KIND_CNT:  PRDATA <= {16'h0000, cnt[dec_rd[2]]};
               default:    PRDATA <= '0;
            endcase
         end
      end
   end

endmodule

// [verif/dma_channel_control_regs_assertions.sv]
// Port-level assertions for the transfer controller
`timescale 1ns/10ps
module dma_ctrl_checker #(
   parameter int ADDR_W = 8
) (
   input wire logic                                CLK_SYS,  // Clock
   input wire logic                                RSTN,     // Reset, active low
   input wire logic                                PSEL,     // APB select
   input wire logic                                PENABLE,  // APB access
   input wire logic                                PWRITE,   // APB direction
   input wire logic [ADDR_W-1:0]                   PADDR,    // APB address
   input wire logic [31:0]                         PRDATA,   // APB read data
   input wire logic                                PSLVERR,  // APB error
   input wire logic [5:0]                          TRIG_IN,  // Sources
   input wire logic [5:0]                          IRQ_OUT,  // Sources to CPU
   input wire logic                                XFER_REQ, // Request
   input wire dma_channel_control_regs_pkg::xfer_t XFER,     // Request details
   input wire logic                                XFER_ACK, // Bus done
   input wire logic [1:0]                          END_IRQ   // End pulses
);
   logic unmapped;
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RSTN);
   // Holes: unaligned words and anything past the two register banks
   assign unmapped = (PADDR[1:0] != 2'h0) || (PADDR[ADDR_W-1:5] != '0);
   // A request waits for its answer, then leaves room for the update cycle
   sequence s_waiting;
      XFER_REQ && !XFER_ACK;
   endsequence
   sequence s_done;
      XFER_REQ && XFER_ACK;
   endsequence
   sequence s_gap;
      !XFER_REQ [*2];
   endsequence
   a_req_holds: assert property (s_waiting |=> XFER_REQ && $stable(XFER))
      else $error("transfer request dropped or changed before acknowledge");
   a_req_gap: assert property (s_done |=> s_gap)
      else $error("transfer request not withdrawn after acknowledge");
   a_addr_top: assert property (XFER_REQ |-> XFER.src[31:24] == 8'hFF && XFER.dst[31:24] == 8'hFF)
      else $error("transfer address top byte not all ones");
   a_irq_subset: assert property ((IRQ_OUT & ~TRIG_IN) == 6'h00)
      else $error("CPU interrupt without its source");
   a_end_single: assert property (END_IRQ != 2'h0 |=> (END_IRQ & $past(END_IRQ)) == 2'h0)
      else $error("end interrupt longer than one cycle");
   a_err_decode: assert property (PSEL && PENABLE |-> PSLVERR == unmapped)
      else $error("slave error does not match address decode");
   a_hole_zero: assert property (PSEL && PENABLE && !PWRITE && unmapped |-> PRDATA == 32'h0)
      else $error("read of a hole returned data");
   a_mar_ones: assert property (PSEL && PENABLE && !PWRITE && !unmapped && PADDR[3:0] == 4'h4 |-> PRDATA[31:24] == 8'hFF)
      else $error("memory address top byte not read as ones");
endmodule

bind dma_channel_control_regs dma_ctrl_checker #(.ADDR_W(ADDR_W)) u_checker (
   .CLK_SYS(CLK_SYS), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .TRIG_IN(TRIG_IN), .IRQ_OUT(IRQ_OUT),
   .XFER_REQ(XFER_REQ), .XFER(XFER), .XFER_ACK(XFER_ACK), .END_IRQ(END_IRQ));

// [verif/xfer_bus_model.sv]
// Bus-side responder that completes transfer requests
`timescale 1ns/10ps
module xfer_bus_model (
   input  wire logic       clk,   // System clock
   input  wire logic       rstn,  // Reset, active low
   input  wire logic       req,   // Transfer request
   input  wire logic [3:0] delay, // Wait cycles before answering
   output logic            ack    // One-cycle completion
);
   logic [3:0] waited;
   // Answer after the chosen wait; a slow bus stretches the request
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack    <= 1'b0;
         waited <= 4'h0;
      end else if (ack || !req) begin
         ack    <= 1'b0;
         waited <= 4'h0;
      end else if (waited >= delay) begin
         ack <= 1'b1;
      end else begin
         waited <= waited + 4'h1;
      end
   end
endmodule

// [verif/dma_channel_control_regs_test.sv]
// Self-checking bench for the two-sub-channel transfer controller
`timescale 1ns/10ps
module dma_channel_control_regs_test;
   logic                                clk = 1'b0, rstn = 1'b0, standby = 1'b0, ext_n = 1'b1;
   logic                                psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic                                pready, pslverr, req, ack, err;
   logic [7:0]                          paddr = 8'h00;
   logic [31:0]                         pwdata = 32'h0, prdata, rd;
   logic [5:0]                          trig = 6'h00, irq, irq_seen;
   logic [3:0]                          delay = 4'h0;
   logic [1:0]                          end_irq;
   dma_channel_control_regs_pkg::xfer_t xfer, x;
   dma_channel_control_regs_pkg::xfer_t seen[$];
   int                                  mismatches = 0, check_count = 0, end_a = 0, end_b = 0;
   dma_channel_control_regs dut (
      .CLK_SYS(clk), .RSTN(rstn), .STANDBY(standby), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .TRIG_IN(trig), .IRQ_OUT(irq), .EXT_REQ_N(ext_n), .XFER_REQ(req), .XFER(xfer),
      .XFER_ACK(ack), .END_IRQ(end_irq));
   xfer_bus_model bus (.clk(clk), .rstn(rstn), .req(req), .delay(delay), .ack(ack));
   // 50 MHz system clock
   always #10 clk = ~clk;
   // Record finished transfers and end pulses
   always @(posedge clk) begin
      if (req && ack)
         seen.push_back(xfer);
      end_a += end_irq[0];
      end_b += end_irq[1];
   end
   task automatic check(input string what, input logic [64:0] exp, input logic [64:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // A wait that ran out counts as a failure
   task automatic hang();
      mismatches++;
      report_and_stop();
   endtask
   // One APB transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (n > 20)
            hang();
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(what, {33'h0, exp}, {33'h0, rd});
   endtask
   // Setting the enable needs a read while it is clear, then the write
   task automatic arm(input logic [7:0] a, input logic [31:0] v);
      apb(1'b0, a, 32'h0);
      apb(1'b1, a, v);
   endtask
   // One-cycle source pulse; the CPU-side copy is caught mid-pulse
   task automatic fire(input int k);
      @(posedge clk);
      trig[k] <= 1'b1;
      @(negedge clk);
      irq_seen = irq;
      @(posedge clk);
      trig[k] <= 1'b0;
   endtask
   // Next finished transfer against expected source, destination, size
   task automatic xchk(input logic [31:0] s, input logic [31:0] dd, input logic wd);
      int n = 0;
      while (seen.size() == 0) begin
         @(posedge clk);
         n++;
         if (n > 60)
            hang();
      end
      x = seen.pop_front();
      check("xfer", {s, dd, wd}, {x.src, x.dst, x.word});
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      // Reset values, refused enable, refused address
      apb(1'b1, 8'h10, 32'h80);
      rdchk("B no arm", 8'h10, 32'h0);
      rdchk("A reset", 8'h00, 32'h0);
      rdchk("hole", 8'h22, 32'h0);
      check("slverr", 65'h1, {64'h0, err});
      apb(1'b1, 8'h04, 32'h12001000);
      rdchk("mar top", 8'h04, 32'hFF001000);
      $display("registers done");
      // I/O mode on A: ignored while off, source masked while on
      apb(1'b1, 8'h08, 32'h40);
      apb(1'b1, 8'h0C, 32'h2);
      fire(2);
      check("irq off", 65'h1, {64'h0, irq_seen[2]});
      repeat (6) @(posedge clk);
      check("ignored", 65'h0, {33'h0, seen.size()});
      arm(8'h00, 32'h8A);
      fire(2);
      check("irq on", 65'h0, {64'h0, irq_seen[2]});
      xchk(32'hFF001000, 32'hFFFFFF40, 1'b0);
      fire(2);
      xchk(32'hFF001001, 32'hFFFFFF40, 1'b0);
      rdchk("A end", 8'h00, 32'h0A);
      rdchk("A count", 8'h0C, 32'h0);
      check("A irq", 65'h1, {33'h0, end_a});
      $display("io mode done");
      // Every source on B in idle mode, with a slower bus each time
      apb(1'b1, 8'h14, 32'h2000);
      apb(1'b1, 8'h18, 32'h77);
      for (int c = 0; c < 8; c++) begin
         delay <= 4'(c);
         apb(1'b1, 8'h1C, 32'h1);
         arm(8'h10, 32'h98 | c);
         if (c < 6)
            fire(c);
         else
            ext_n <= 1'b0;
         if (c == 5)
            xchk(32'hFFFFFF77, 32'hFF002000, 1'b0);
         else
            xchk(32'hFF002000, 32'hFFFFFF77, 1'b0);
         ext_n <= 1'b1;
         rdchk("B end", 8'h10, 32'h18 | c);
      end
      check("B irq", 65'h8, {33'h0, end_b});
      $display("sources done");
      // Repeat mode on B: words step down, enable stays, standby clears it
      apb(1'b1, 8'h14, 32'h3000);
      apb(1'b1, 8'h18, 32'h55);
      apb(1'b1, 8'h1C, 32'h0101);
      arm(8'h10, 32'hF1);
      for (int i = 0; i < 3; i++) begin
         fire(1);
         xchk(32'hFF003000 - 2 * i, 32'hFFFFFF55, 1'b1);
      end
      rdchk("B repeat", 8'h10, 32'hF1);
      standby <= 1'b1;
      repeat (2) @(posedge clk);
      standby <= 1'b0;
      rdchk("B standby", 8'h10, 32'h0);
      check("B irq quiet", 65'h8, {33'h0, end_b});
      rdchk("B mar kept", 8'h14, 32'hFF002FFA);
      $display("repeat done");
      // One shared source for A and B: A goes first
      apb(1'b1, 8'h04, 32'h100);
      apb(1'b1, 8'h0C, 32'h1);
      apb(1'b1, 8'h1C, 32'h1);
      arm(8'h00, 32'h83);
      arm(8'h10, 32'h83);
      fire(3);
      xchk(32'hFF000100, 32'hFFFFFF40, 1'b0);
      xchk(32'hFF002FFA, 32'hFFFFFF55, 1'b0);
      $display("priority done");
      // Full mode: A address source, B address destination, A count ends it
      apb(1'b1, 8'h04, 32'h2000);
      apb(1'b1, 8'h14, 32'h3000);
      apb(1'b1, 8'h0C, 32'h2);
      apb(1'b1, 8'h10, 32'h14);
      arm(8'h00, 32'hDE);
      for (int i = 0; i < 2; i++) begin
         fire(4);
         xchk(32'hFF002000 + 2 * i, 32'hFF003000 + 2 * i, 1'b1);
      end
      rdchk("full end", 8'h00, 32'h5E);
      check("A irq 2", 65'h2, {33'h0, end_a});
      // Block mode: size byte reloads, block counter ends the run
      apb(1'b1, 8'h0C, 32'h0202);
      apb(1'b1, 8'h1C, 32'h1);
      arm(8'h00, 32'h87);
      fire(4);
      xchk(32'hFF002004, 32'hFF003004, 1'b0);
      rdchk("blk unit", 8'h0C, 32'h0102);
      fire(4);
      xchk(32'hFF002004, 32'hFF003005, 1'b0);
      rdchk("blk reload", 8'h0C, 32'h0202);
      rdchk("blk count", 8'h1C, 32'h0);
      rdchk("blk end", 8'h00, 32'h07);
      $display("full mode done");
      // A reset after the run has ended clears control but keeps addresses
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rdchk("A reset 2", 8'h00, 32'h0);
      rdchk("A mar kept", 8'h04, 32'hFF002004);
      $display("reset done");
      report_and_stop();
   end
endmodule
